/* File: rtl/wdri_byte_reg.sv */
// One byte of the watchdog reload value with its own write strobe
`timescale 1ns/1ps
`default_nettype none
module wdri_byte_reg #(
  parameter logic [7:0] RESET_VAL = 8'h00
) (
  input wire logic pclk, // System clock
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic wr_en, // Write strobe for this byte
  input wire wdri_pkg::wdri_byte_t wr_data, // Byte to store
  output var wdri_pkg::wdri_byte_t q // Stored byte
);
  import wdri_pkg::*;

  wdri_byte_t q_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_ff <= RESET_VAL;
    end else if (wr_en) begin
      q_ff <= wr_data;
    end
  end

  assign q = q_ff;
endmodule
`default_nettype wire

/* File: rtl/wdri_consts.svh */
// Address indices, field positions, reset values and timing counts of the watchdog registers
`ifndef WDRI_CONSTS_SVH
`define WDRI_CONSTS_SVH

// Register indices; byte address on APB is four times the index
`define WDRI_IDX_UNLOCK 12'hFF0
`define WDRI_IDX_CAUSE 12'hFF0
`define WDRI_IDX_UPPER 12'hFF1
`define WDRI_IDX_HIGH 12'hFF2
`define WDRI_IDX_LOW 12'hFF3

// Reset-cause field positions
`define WDRI_POS_POR 7
`define WDRI_POS_STOP 6
`define WDRI_POS_TIMEOUT 5
`define WDRI_POS_PIN 4

// Reset values
`define WDRI_RST_UPPER 8'h00
`define WDRI_RST_HIGH 8'h04
`define WDRI_RST_LOW 8'h00
`define WDRI_RST_RELOAD 24'h000400
`define WDRI_RST_CAUSE 4'h8
`define WDRI_RST_UNLOCK 8'h00

// Watchdog tick period and system clock period, in ns
`define WDRI_TICK_NS 100000
`define WDRI_CLK_NS 4
`define WDRI_TICK_CYC (`WDRI_TICK_NS / `WDRI_CLK_NS)

`endif

/* File: rtl/wdri_pkg.sv */
// Types shared by the watchdog register interface
package wdri_pkg;
  typedef logic [13:0] wdri_addr_t;
  typedef logic [31:0] wdri_data_t;
  typedef logic [7:0] wdri_byte_t;
  typedef logic [23:0] wdri_count_t;
  typedef enum logic [2:0] {
    WDRI_SEL_FF0 = 3'b000,
    WDRI_SEL_UPPER = 3'b001,
    WDRI_SEL_HIGH = 3'b010,
    WDRI_SEL_LOW = 3'b011,
    WDRI_SEL_NONE = 3'b100
  } wdri_sel_t;
endpackage

/* File: rtl/wdri_top.sv */
// APB register interface of the watchdog: unlock, reset cause, reload bytes and counter
`timescale 1ns/1ps
`include "wdri_consts.svh"
`default_nettype none
module wdri_top #(
  parameter int TICK_CYC = `WDRI_TICK_CYC
) (
  input wire logic pclk, // System clock, 250 MHz
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction, high for write
  input wire wdri_pkg::wdri_addr_t paddr, // APB byte address
  input wire wdri_pkg::wdri_data_t pwdata, // APB write data
  output var wdri_pkg::wdri_data_t prdata, // APB read data
  output var logic pready, // APB ready
  output var logic pslverr, // APB error on unmapped address
  input wire logic stop_recovery_event, // Pulse: recovered from stop mode
  input wire logic pin_reset_event, // Pulse: reset pin was asserted
  input wire logic refresh, // Pulse: reload counter from reload value
  output var logic watchdog_timeout, // Pulse: counter reached zero
  output var logic unlock_write, // Pulse: unlock register was written
  output var wdri_pkg::wdri_byte_t unlock_value // Last value written to unlock
);
  import wdri_pkg::*;

  localparam wdri_addr_t ADDR_FF0 = {`WDRI_IDX_UNLOCK, 2'b00};
  localparam wdri_addr_t ADDR_UPPER = {`WDRI_IDX_UPPER, 2'b00};
  localparam wdri_addr_t ADDR_HIGH = {`WDRI_IDX_HIGH, 2'b00};
  localparam wdri_addr_t ADDR_LOW = {`WDRI_IDX_LOW, 2'b00};
  localparam int TICK_W = (TICK_CYC > 1) ? $clog2(TICK_CYC) : 1;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYC - 1);

  // Address decode
  wdri_sel_t sel;
  assign sel = (paddr == ADDR_FF0) ? WDRI_SEL_FF0 :
               (paddr == ADDR_UPPER) ? WDRI_SEL_UPPER :
               (paddr == ADDR_HIGH) ? WDRI_SEL_HIGH :
               (paddr == ADDR_LOW) ? WDRI_SEL_LOW : WDRI_SEL_NONE;

  logic pready_ff;
  wire logic setup_ph;
  wire logic access_done;
  wire logic wr_done;
  wire logic rd_done;
  assign setup_ph = psel & ~penable;
  assign access_done = psel & penable & pready_ff;
  assign wr_done = access_done & pwrite & (sel != WDRI_SEL_NONE);
  assign rd_done = access_done & ~pwrite & (sel != WDRI_SEL_NONE);

  wire logic wr_unlock;
  wire logic wr_upper;
  wire logic wr_high;
  wire logic wr_low;
  wire logic rd_cause;
  assign wr_unlock = wr_done & (sel == WDRI_SEL_FF0);
  assign wr_upper = wr_done & (sel == WDRI_SEL_UPPER);
  assign wr_high = wr_done & (sel == WDRI_SEL_HIGH);
  assign wr_low = wr_done & (sel == WDRI_SEL_LOW);
  assign rd_cause = rd_done & (sel == WDRI_SEL_FF0);

  // Reload value bytes
  wdri_byte_t reload_upper_byte;
  wdri_byte_t reload_high_byte;
  wdri_byte_t reload_low_byte;
  wdri_count_t reload_value;

  wdri_byte_reg #(.RESET_VAL(`WDRI_RST_UPPER)) u_upper (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_upper),
    .wr_data(pwdata[7:0]),
    .q(reload_upper_byte)
  );
  wdri_byte_reg #(.RESET_VAL(`WDRI_RST_HIGH)) u_high (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_high),
    .wr_data(pwdata[7:0]),
    .q(reload_high_byte)
  );
  wdri_byte_reg #(.RESET_VAL(`WDRI_RST_LOW)) u_low (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_low),
    .wr_data(pwdata[7:0]),
    .q(reload_low_byte)
  );
  assign reload_value = {reload_upper_byte, reload_high_byte, reload_low_byte};

  // Tick divider and down counter
  logic [TICK_W-1:0] tick_cnt_ff;
  logic tick_ff;
  wdri_count_t count_ff;
  wdri_count_t nxt_count;
  wire logic at_zero;
  assign at_zero = (count_ff == 24'h000000);
  // Reload writes only reach the counter through refresh or expiry
  assign nxt_count = refresh ? reload_value :
                     !tick_ff ? count_ff :
                     at_zero ? reload_value : count_ff - 24'h000001;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= (tick_cnt_ff == TICK_LAST);
      tick_cnt_ff <= (tick_cnt_ff == TICK_LAST) ? '0 : tick_cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_ff <= `WDRI_RST_RELOAD;
    end else begin
      count_ff <= nxt_count;
    end
  end

  // Reset cause flags: bits 7..4, power-on set by reset itself
  logic [3:0] cause_ff;
  logic [3:0] nxt_cause;
  wire logic [3:0] cause_set;
  wire logic expire;
  assign expire = tick_ff & at_zero & ~refresh;
  assign cause_set = {1'b0, stop_recovery_event, expire, pin_reset_event};
  // Read clears, but an event in the same cycle survives
  assign nxt_cause = (rd_cause ? 4'h0 : cause_ff) | cause_set;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_ff <= `WDRI_RST_CAUSE;
    end else begin
      cause_ff <= nxt_cause;
    end
  end

  // Unlock register
  wdri_byte_t unlock_ff;
  logic unlock_write_ff;
  logic timeout_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unlock_ff <= `WDRI_RST_UNLOCK;
      unlock_write_ff <= 1'b0;
      timeout_ff <= 1'b0;
    end else begin
      if (wr_unlock) begin
        unlock_ff <= pwdata[7:0];
      end
      unlock_write_ff <= wr_unlock;
      timeout_ff <= expire;
    end
  end

  // APB answer: ready in the first access cycle, data captured at setup
  wdri_data_t rdata_ff;
  wdri_data_t nxt_rdata;
  logic pslverr_ff;
  always_comb begin
    nxt_rdata = 32'h00000000;
    unique case (sel)
      WDRI_SEL_FF0: nxt_rdata[7:0] = {cause_ff, 4'h0};
      WDRI_SEL_UPPER: nxt_rdata[7:0] = count_ff[23:16];
      WDRI_SEL_HIGH: nxt_rdata[7:0] = count_ff[15:8];
      WDRI_SEL_LOW: nxt_rdata[7:0] = count_ff[7:0];
      WDRI_SEL_NONE: nxt_rdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_ff <= 32'h00000000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= setup_ph;
      pslverr_ff <= setup_ph & (sel == WDRI_SEL_NONE);
      if (setup_ph && !pwrite) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  assign prdata = rdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign watchdog_timeout = timeout_ff;
  assign unlock_write = unlock_write_ff;
  assign unlock_value = unlock_ff;

  // Checks
  apb_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
    setup_ph |=> pready)
    else $error("pready missing after setup");

  unlock_store_a: assert property (@(posedge pclk) disable iff (!presetn)
    (access_done && pwrite && paddr == ADDR_FF0) |=>
      (unlock_value == $past(pwdata[7:0])) && unlock_write)
    else $error("unlock write not stored");

  cause_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_ph && !pwrite && paddr == ADDR_FF0) |=>
      prdata == {24'h000000, $past(cause_ff), 4'h0})
    else $error("control address read not reset cause");

  timeout_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    expire |=> cause_ff[`WDRI_POS_TIMEOUT - 4] && watchdog_timeout)
    else $error("timeout flag not set on expiry");

  count_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_ph && !pwrite && paddr == ADDR_HIGH) |=>
      prdata == {24'h000000, $past(count_ff[15:8])})
    else $error("reload byte read not counter");

  reload_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    (access_done && pwrite && paddr == ADDR_UPPER && !refresh && !tick_ff) |=>
      (reload_value[23:16] == $past(pwdata[7:0])) && $stable(count_ff))
    else $error("reload write wrong or touched counter");

  byte_only_a: assert property (@(posedge pclk) disable iff (!presetn)
    (access_done && pwrite && paddr == ADDR_LOW) |=>
      $stable(reload_value[23:8]) && reload_value[7:0] == $past(pwdata[7:0]))
    else $error("reload write changed other bytes");

  reload_default_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> reload_value == `WDRI_RST_RELOAD)
    else $error("reload default wrong after reset");

  unmapped_err_a: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_ph && sel == WDRI_SEL_NONE) |=> pslverr && pready)
    else $error("unmapped access not flagged");
endmodule
`default_nettype wire

/* File: test/wdri_top_test.sv */
// Self-checking testbench of the watchdog register interface
`timescale 1ns/1ps
`include "wdri_consts.svh"
`default_nettype none
module wdri_top_test;
  import wdri_pkg::*;
  logic pclk, presetn, psel, penable, pwrite;
  logic stop_recovery_event, pin_reset_event, refresh;
  wdri_addr_t paddr;
  wdri_data_t pwdata, prdata, rd;
  logic pready, pslverr, watchdog_timeout, unlock_write, err;
  wdri_byte_t unlock_value, u, h, h2, l, prev_u;
  int n_mismatch = 0;
  int compares = 0;
  int n;

  wdri_top #(.TICK_CYC(4)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .stop_recovery_event(stop_recovery_event),
    .pin_reset_event(pin_reset_event), .refresh(refresh),
    .watchdog_timeout(watchdog_timeout), .unlock_write(unlock_write),
    .unlock_value(unlock_value));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  function automatic wdri_addr_t ba(logic [11:0] idx);
    return {idx, 2'b00};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input wdri_addr_t a, input wdri_data_t d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    // A slave that never answers counts against the run
    if (pready !== 1'b1) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, pready, 1'b1);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // One-cycle pulse on an event input
  task automatic pulse(input int which);
    @(posedge pclk);
    if (which == 0) stop_recovery_event <= 1'b1;
    else if (which == 1) pin_reset_event <= 1'b1;
    else refresh <= 1'b1;
    @(posedge pclk);
    stop_recovery_event <= 1'b0;
    pin_reset_event <= 1'b0;
    refresh <= 1'b0;
  endtask

  task automatic conclude();
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    #100000;
    n_mismatch++;
    conclude();
  end

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, stop_recovery_event, pin_reset_event, refresh} = '0;
    paddr = '0;
    pwdata = '0;
    void'($urandom(87520));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    // Default reload 0x000400 at four cycles a tick sets the first expiry
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (watchdog_timeout !== 1'b1 && n < 6000);
    chk(n >= 32'h400 * 4 && n <= 32'h401 * 4 + 4, 1);
    apb(0, ba(`WDRI_IDX_CAUSE), 0);
    chk(rd, 32'hA0);
    apb(0, ba(`WDRI_IDX_CAUSE), 0);
    chk(rd, 32'h00);
    apb(0, 14'h3FD0, 0);
    chk(err, 1);
    chk(rd, 32'h0);
    pulse(0);
    pulse(1);
    u = 8'($urandom);
    apb(1, ba(`WDRI_IDX_UNLOCK), {24'h0, u});
    @(posedge pclk);
    chk(unlock_write, 1);
    chk(unlock_value, u);
    apb(0, ba(`WDRI_IDX_CAUSE), 0);
    chk(rd, 32'h50);
    chk(unlock_value, u);
    prev_u = 8'h00;
    repeat (4) begin
      u = 8'($urandom);
      h = 8'($urandom);
      h2 = 8'($urandom);
      l = 8'($urandom) | 8'h80;
      apb(1, ba(`WDRI_IDX_UPPER), {24'h0, u});
      apb(0, ba(`WDRI_IDX_UPPER), 0);
      chk(rd, {24'h0, prev_u});
      apb(1, ba(`WDRI_IDX_HIGH), {24'h0, h});
      apb(1, ba(`WDRI_IDX_LOW), {24'h0, l});
      apb(1, ba(`WDRI_IDX_HIGH), {24'h0, h2});
      pulse(2);
      apb(0, ba(`WDRI_IDX_UPPER), 0);
      chk(rd, {24'h0, u});
      apb(0, ba(`WDRI_IDX_HIGH), 0);
      chk(rd, {24'h0, h2});
      apb(0, ba(`WDRI_IDX_LOW), 0);
      chk(rd[31:8] == 0 && l - rd[7:0] <= 8, 1);
      prev_u = u;
    end
    conclude();
  end
endmodule
`default_nettype wire
